// file: rtl/tfc_cell.v
// Purpose: three-tap transversal filter slice with cascade sum
// Assumes: inputs synchronous to clock_i, 100 MHz single clock
// Notes:   pins driven with separate output enables, no tristate
`timescale 1ns/10ps
`include "tfc_defines.vh"

// What this block does
// - output sums delayed sum-in and three products
// - select one high bypasses sum-in register
// - select one low registers sum-in
// - bypass keeps full pipelined throughput
// - inputs taken at edge, sum-in later bypassed
// - each select low inserts one delay stage
// - coefficients rewritable during filtering
// - select one low others high delays
// - write select picks target coefficient
// - coefficient and select registered then written
// - overflow flag registered, clears on next
// - half-lsb rounding, sixteen msbs out
module tfc_cell
(
  input  wire                  clock_i,
  input  wire                  rstn_i,
  input  wire                  ce_i,
  input  wire [`TFC_DW-1:0]    sample_input_i,
  input  wire [`TFC_SW-1:0]    sum_in_i,
  input  wire [`TFC_DW-1:0]    coef_input_i,
  input  wire [1:0]            coef_write_select_i,
  input  wire                  sum_in_feedthrough_sel_i,
  input  wire                  mid_feedthrough_sel_i,
  input  wire                  last_feedthrough_sel_i,
  input  wire                  out_enable_n_i,
  output reg  [`TFC_SW-1:0]    sum_out_o,
  output wire                  sum_out_oe_o,
  output reg                   sum_overflow_flag_o,
  output wire                  sum_overflow_flag_oe_o
);

  reg                          rst_s1;
  reg                          rst_s2;
  reg  [`TFC_DW-1:0]           coef_hold;
  reg  [1:0]                   cwe_hold;
  reg  signed [`TFC_DW-1:0]    dly [1:`TFC_DDEPTH];
  reg  [`TFC_SW-1:0]           sdl [1:`TFC_SDEPTH];
  wire [`TFC_DW-1:0]           coef_reg_first;
  wire [`TFC_DW-1:0]           coef_reg_second;
  wire [`TFC_DW-1:0]           coef_reg_third;
  reg  [2:0]                   tap_c2;
  reg  [2:0]                   tap_c1;
  reg  [2:0]                   tap_s;
  reg  [`TFC_SW-1:0]           next_sum_out;
  reg                          next_sum_overflow_flag;
  wire signed [`TFC_PW-1:0]    prod_first;
  wire signed [`TFC_PW-1:0]    prod_second;
  wire signed [`TFC_PW-1:0]    prod_third;
  wire signed [`TFC_AW-1:0]    sum_ext;
  wire signed [`TFC_AW-1:0]    next_total;
  wire                         next_overflow;
  integer                      k;

  // reset release through two flops
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // select and word caught together, written one edge later
  always @(posedge clock_i or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      cwe_hold  <= `TFC_CWE_NONE;
      coef_hold <= {`TFC_DW{1'b0}};
    end
    else if (ce_i)
    begin
      cwe_hold  <= coef_write_select_i;
      coef_hold <= coef_input_i;
    end
  end

  // select 00 touches no register and ignores the bus
  tfc_coef_reg u_coef_first
  (
    .clock_i (clock_i),
    .ce_i    (ce_i),
    .load_i  (cwe_hold == `TFC_CWE_FIRST),
    .data_i  (coef_hold),
    .coef_o  (coef_reg_first)
  );

  tfc_coef_reg u_coef_second
  (
    .clock_i (clock_i),
    .ce_i    (ce_i),
    .load_i  (cwe_hold == `TFC_CWE_SEC),
    .data_i  (coef_hold),
    .coef_o  (coef_reg_second)
  );

  tfc_coef_reg u_coef_third
  (
    .clock_i (clock_i),
    .ce_i    (ce_i),
    .load_i  (cwe_hold == `TFC_CWE_THIRD),
    .data_i  (coef_hold),
    .coef_o  (coef_reg_third)
  );

  // sample and sum-in delay lines; data pipes carry no reset
  always @(posedge clock_i)
  begin
    if (ce_i)
    begin
      dly[1] <= sample_input_i;
      sdl[1] <= sum_in_i;
      for (k = 2; k <= `TFC_DDEPTH; k = k + 1)
      begin
        dly[k] <= dly[k-1];
      end
      for (k = 2; k <= `TFC_SDEPTH; k = k + 1)
      begin
        sdl[k] <= sdl[k-1];
      end
    end
  end

  // each high select removes one register from the path
  always @*
  begin
    tap_c2 = `TFC_D2_TAP;
    if (last_feedthrough_sel_i)
    begin
      tap_c2 = tap_c2 - `TFC_FT_STEP;
    end
  end

  always @*
  begin
    tap_c1 = `TFC_D1_TAP;
    if (last_feedthrough_sel_i)
    begin
      tap_c1 = tap_c1 - `TFC_FT_STEP;
    end
    if (mid_feedthrough_sel_i)
    begin
      tap_c1 = tap_c1 - `TFC_FT_STEP;
    end
  end

  // sum-in bypass takes the later sample, one stage shorter
  always @*
  begin
    tap_s = `TFC_S_TAP;
    if (sum_in_feedthrough_sel_i)
    begin
      tap_s = tap_s - `TFC_FT_STEP;
    end
    if (mid_feedthrough_sel_i)
    begin
      tap_s = tap_s - `TFC_FT_STEP;
    end
    if (last_feedthrough_sel_i)
    begin
      tap_s = tap_s - `TFC_FT_STEP;
    end
  end

  assign prod_third  = dly[`TFC_D3_TAP] * $signed(coef_reg_third);
  assign prod_second = dly[tap_c2] * $signed(coef_reg_second);
  assign prod_first  = dly[tap_c1] * $signed(coef_reg_first);

  // half-lsb rounding below the sum-in word
  assign sum_ext = {sdl[tap_s][`TFC_SW-1], sdl[tap_s], `TFC_RND};

  assign next_total = sum_ext
                    + {{(`TFC_AW-`TFC_PW){prod_first[`TFC_PW-1]}},
                       prod_first}
                    + {{(`TFC_AW-`TFC_PW){prod_second[`TFC_PW-1]}},
                       prod_second}
                    + {{(`TFC_AW-`TFC_PW){prod_third[`TFC_PW-1]}},
                       prod_third};

  // result no longer fits the 22-bit signed field
  assign next_overflow = next_total[`TFC_AW-1]
                         ^ next_total[`TFC_AW-2];

  // hold last result while frozen
  always @*
  begin
    next_sum_out           = sum_out_o;
    next_sum_overflow_flag = sum_overflow_flag_o;
    if (ce_i)
    begin
      next_sum_out           = next_total[`TFC_AW-2:`TFC_LSB];
      next_sum_overflow_flag = next_overflow;
    end
  end

  always @(posedge clock_i or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      sum_out_o           <= {`TFC_SW{1'b0}};
      sum_overflow_flag_o <= 1'b0;
    end
    else
    begin
      sum_out_o           <= next_sum_out;
      sum_overflow_flag_o <= next_sum_overflow_flag;
    end
  end

  // enables are combinational so disable takes effect at once
  assign sum_out_oe_o           = ~out_enable_n_i;
  assign sum_overflow_flag_oe_o = ~out_enable_n_i;

endmodule

// file: rtl/tfc_defines.vh
// Purpose: constants for the three-tap cascadable filter cell
// Assumes: included by bare name from rtl files
// Notes:   widths follow the data formats of the cell
`ifndef TFC_DEFINES_VH
`define TFC_DEFINES_VH

`define TFC_DW        10
`define TFC_SW        16
`define TFC_PW        20
`define TFC_AW        23
`define TFC_LSB       6
`define TFC_RND       6'h20
`define TFC_CWE_NONE  2'h0
`define TFC_CWE_FIRST 2'h1
`define TFC_CWE_SEC   2'h2
`define TFC_CWE_THIRD 2'h3
`define TFC_DDEPTH    6
`define TFC_SDEPTH    5
`define TFC_D3_TAP    3'h2
`define TFC_D2_TAP    3'h4
`define TFC_D1_TAP    3'h6
`define TFC_S_TAP     3'h5
`define TFC_FT_STEP   3'h1

`endif

// file: rtl/tfc_coef_reg.v
// Purpose: one loadable coefficient register
// Assumes: single clock, clock enable freezes contents
// Notes:   no reset, contents undefined until loaded
`timescale 1ns/10ps
`include "tfc_defines.vh"

module tfc_coef_reg
(
  input  wire                  clock_i,
  input  wire                  ce_i,
  input  wire                  load_i,
  input  wire [`TFC_DW-1:0]    data_i,
  output reg  [`TFC_DW-1:0]    coef_o
);

  // coefficients are never cleared by the cell itself
  always @(posedge clock_i)
  begin
    if (ce_i && load_i)
    begin
      coef_o <= data_i;
    end
  end

endmodule

// file: dv/tfc_cell_properties.sv
// Purpose: port checks for the filter cell
// Assumes: bound to tfc_cell in the bench top
// Notes:   zero-data windows isolate the sum-in path
`timescale 1ns/10ps
module tfc_props
(
  input wire        clock_i,
  input wire        rstn_i,
  input wire        ce_i,
  input wire [9:0]  sample_input_i,
  input wire [15:0] sum_in_i,
  input wire [9:0]  coef_input_i,
  input wire [1:0]  coef_write_select_i,
  input wire        sum_in_feedthrough_sel_i,
  input wire        mid_feedthrough_sel_i,
  input wire        last_feedthrough_sel_i,
  input wire        out_enable_n_i,
  input wire [15:0] sum_out_o,
  input wire        sum_out_oe_o,
  input wire        sum_overflow_flag_o,
  input wire        sum_overflow_flag_oe_o
);
  wire [2:0] ft = {last_feedthrough_sel_i, mid_feedthrough_sel_i,
                   sum_in_feedthrough_sel_i};
  reg  [3:0] run_q;
  reg  [2:0] ft_q;
  // enabled edges with zero data and steady selects, so no product leaks
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      {run_q, ft_q} <= 7'h00;
    else
    begin
      ft_q  <= ft;
      run_q <= (!ce_i || sample_input_i != 10'h000 || ft != ft_q) ? 4'h0 :
               run_q + {3'h0, run_q != 4'hF};
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  sequence settled_s;
    run_q >= 4'h8 && ft == ft_q;
  endsequence
  sum_oe_a: assert property (sum_out_oe_o == !out_enable_n_i)
    else $error("sum enable wrong");
  flag_oe_a: assert property (sum_overflow_flag_oe_o == !out_enable_n_i)
    else $error("flag enable wrong");
  hold_out_a: assert property (!ce_i |=> $stable(sum_out_o))
    else $error("output moved while frozen");
  no_zero_a: assert property (settled_s ##0 (ft == 3'h7) |->
    sum_out_o == $past(sum_in_i, 3)) else $error("sum delay wrong, 111");
  two_zero_a: assert property (settled_s ##0 (ft == 3'h1) |->
    sum_out_o == $past(sum_in_i, 5)) else $error("sum delay wrong, 001");
  one_zero_a: assert property (settled_s ##0 (ft == 3'h6) |->
    sum_out_o == $past(sum_in_i, 4)) else $error("sum delay wrong, 110");
  three_zero_a: assert property (settled_s ##0 (ft == 3'h0) |->
    sum_out_o == $past(sum_in_i, 6)) else $error("sum delay wrong, 000");
  no_ovf_a: assert property (settled_s |-> !sum_overflow_flag_o)
    else $error("overflow without cause");
endmodule

// file: dv/tfc_upstream.sv
// Purpose: upstream slice feeding sum-in
// Assumes: bench supplies the next sum word
// Notes:   registered, so sum-in is steady a whole cycle
`timescale 1ns/10ps
module tfc_upstream
(
  input  wire        clock_i,
  input  wire [15:0] next_i,
  output reg  [15:0] sum_o = 16'h0000
);
  always @(posedge clock_i) sum_o <= next_i;
endmodule

// file: dv/test_tfc_cell.sv
// Purpose: self-checking bench for the filter cell
// Assumes: reference sums rebuilt from recorded inputs
// Notes:   checks pause after each coef or select change
`timescale 1ns/10ps
module test_tfc_cell;
  reg         clock_i = 0, rstn_i = 0, ce_i = 1, oe_n = 0;
  reg  [9:0]  din = 0, cin = 0;
  reg  [1:0]  cws = 0;
  reg  [2:0]  ft = 0;
  reg  [15:0] nxt = 0;
  wire [15:0] sum_in_i, so;
  wire        ov, soe, foe;
  reg  signed [9:0]  di [0:1023];
  reg  signed [15:0] si [0:1023];
  integer e = 0, q = 0, cyc = 0, fails = 0, n_compared = 0, t, k, s;
  integer cf [1:3];
  always #5 clock_i = ~clock_i;
  tfc_upstream UP (.clock_i(clock_i), .next_i(nxt), .sum_o(sum_in_i));
  tfc_cell DUT (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .sample_input_i(din), .sum_in_i(sum_in_i), .coef_input_i(cin),
    .coef_write_select_i(cws), .sum_in_feedthrough_sel_i(ft[0]),
    .mid_feedthrough_sel_i(ft[1]), .last_feedthrough_sel_i(ft[2]),
    .out_enable_n_i(oe_n), .sum_out_o(so), .sum_out_oe_o(soe),
    .sum_overflow_flag_o(ov), .sum_overflow_flag_oe_o(foe));
  task close_out;
  begin
    if (fails == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  always @(posedge clock_i)
  begin
    cyc = cyc + 1;
    if (cyc == 1000)
    begin
      fails = fails + 1;
      close_out;
    end
    if (ce_i && rstn_i)
    begin
      e = e + 1;
      q = q + 1;
      di[e] = din;
      si[e] = sum_in_i;
    end
  end
  task step(input [1:0] sel, input [9:0] c);
  begin
    @(negedge clock_i);
    t = (si[e-5+ft[0]+ft[1]+ft[2]] <<< 6) + 32 + cf[1] * di[e-6+ft[1]+ft[2]]
      + cf[2] * di[e-4+ft[2]] + cf[3] * di[e-2];
    n_compared = n_compared + (q > 12);
    if (q > 12 && (so !== t[21:6] || ov !== (t[22] ^ t[21])
        || soe !== !oe_n || foe !== !oe_n))
    begin
      fails = fails + 1;
      $display("mismatch at %0t: sum out %h", $time, so);
    end
    @(posedge clock_i);
    cws  <= sel;
    cin  <= c;
    ce_i <= (cyc % 29 != 0) || sel != 2'h0;
    din  <= cyc[4] ? 10'h000 : cyc[9:0] * 10'h025;
    nxt  <= cyc[15:0] * 16'h2345;
    oe_n <= cyc[3] & cyc[2];
  end
  endtask
  initial
  begin
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (3) step(2'h0, 10'h2AA);
    for (k = 0; k < 8; k = k + 1)
    begin
      cf[1] = k - 512;
      cf[2] = 511 - 9 * k;
      cf[3] = 341 - 90 * k;
      ft <= k[2:0];
      q = 0;
      for (s = 1; s < 4; s = s + 1)
        step(s[1:0], cf[s][9:0]);
      repeat (48) step(2'h0, 10'h2AA);
    end
    close_out;
  end
endmodule
bind tfc_cell tfc_props chk (.clock_i, .rstn_i, .ce_i, .sample_input_i,
  .sum_in_i, .coef_input_i, .coef_write_select_i, .sum_in_feedthrough_sel_i,
  .mid_feedthrough_sel_i, .last_feedthrough_sel_i, .out_enable_n_i,
  .sum_out_o, .sum_out_oe_o, .sum_overflow_flag_o, .sum_overflow_flag_oe_o);
